// ---- bench/npic_chk.sv ----
// Purpose: port-level checks of the nested interrupt controller
// Assumes: one clock domain, reset active low
// Notes: bound into npic_ctrl
`timescale 1ns/1ps
module npic_chk (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// cpu side
	input wire logic cpu_return_from_isr,
	input wire logic [1:0] cpu_return_from_isr_prio,
	input wire logic busy,
	input wire npic_pkg::npic_save_t save,
	input wire npic_pkg::npic_vec_t vec,
	input wire logic [1:0] cc_prio
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// four pushes in order, then the vector
	property p_push_seq;
		(save.push && save.item == 2'h0) |=> (save.push && save.item == 2'h1)
			##1 (save.push && save.item == 2'h2) ##1 (save.push && save.item == 2'h3)
			##1 vec.load;
	endproperty
	a_push_seq: assert property (p_push_seq) else $error("push order broken");
	property p_push_first;
		save.push && !$past(save.push) |-> save.item == 2'h0;
	endproperty
	a_push_first: assert property (p_push_first) else $error("first push not pc");
	property p_push_load;
		vec.load && vec.addr != 16'hFFFE |-> $past(save.push) && $past(save.item) == 2'h3;
	endproperty
	a_push_load: assert property (p_push_load) else $error("vector without context");
	property p_nmi_lvl;
		vec.load && vec.addr[15:2] == 14'h3FFF |-> cc_prio == 2'h3;
	endproperty
	a_nmi_lvl: assert property (p_nmi_lvl) else $error("nmi level not 3");
	property p_vec_range;
		vec.load |-> vec.addr >= 16'hFFE0 && !vec.addr[0];
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector out of range");
	property p_load_pulse;
		vec.load |=> !vec.load;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load too long");
	property p_addr_hold;
		!vec.load |-> $stable(vec.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("vector moved");
	property p_return_from_isr;
		cpu_return_from_isr && !busy |=> cc_prio == $past(cpu_return_from_isr_prio);
	endproperty
	a_return_from_isr: assert property (p_return_from_isr) else $error("level not restored");
	c_trap: cover property (vec.load && vec.addr == 16'hFFFC);
	c_nest: cover property (vec.load && cc_prio == 2'h1);
	c_return_from_isr: cover property (cpu_return_from_isr && !busy);
endmodule

bind npic_ctrl npic_chk npic_chk_i (
	.hclk(hclk),
	.hresetn(hresetn),
	.cpu_return_from_isr(cpu_return_from_isr),
	.cpu_return_from_isr_prio(cpu_return_from_isr_prio),
	.busy(busy),
	.save(save),
	.vec(vec),
	.cc_prio(cc_prio)
);

// ---- bench/npic_cpu_model.sv ----
// Purpose: cpu core model, instruction ends and context stack
// Assumes: slow gives one instruction end in three cycles
// Notes: stacks the level at the context push, pops it on return
`timescale 1ns/1ps
module npic_cpu_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bench control
	input wire logic slow,
	input wire logic return_from_isr_req,
	// controller side
	input wire npic_pkg::npic_save_t save,
	input wire logic [1:0] cc_prio,
	output logic cpu_instr_end,
	output logic cpu_return_from_isr,
	output logic [1:0] cpu_return_from_isr_prio
);
	logic [1:0] stk[$];
	logic [1:0] cnt;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 2'h0;
			cpu_instr_end <= 1'b0;
			cpu_return_from_isr <= 1'b0;
			cpu_return_from_isr_prio <= 2'h2;
			stk.delete();
		end else begin
			cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
			cpu_instr_end <= !slow || cnt == 2'h0;
			cpu_return_from_isr <= return_from_isr_req;
			if (save.push && save.item == 2'h3)
				stk.push_back(cc_prio);
			if (return_from_isr_req && stk.size() > 0)
				cpu_return_from_isr_prio <= stk.pop_back();
			else
				cpu_return_from_isr_prio <= ~cpu_return_from_isr_prio;
		end
	end
endmodule

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the nested interrupt controller
// Assumes: hreadyout feeds hready, zero wait states
// Notes: vector loads are checked against a queue of notes
`timescale 1ns/1ps
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [7:0] ext0_pins = 8'hFF;
	logic [7:0] ext1_pins = 8'hFF;
	logic cpu_wait = 1'b0;
	logic cpu_stop = 1'b0;
	logic [13:0] periph_flag = 14'h0;
	logic [13:0] periph_en = 14'h3FFC;
	logic [13:0] periph_clr = 14'h0;
	logic cpu_trap = 1'b0;
	logic slow = 1'b0;
	logic return_from_isr_req = 1'b0;
	logic hreadyout, hresp, cpu_instr_end, cpu_return_from_isr, wake_wait, wake_stop, busy;
	logic [31:0] hrdata;
	logic [1:0] cpu_return_from_isr_prio, cc_prio;
	npic_pkg::npic_save_t save;
	npic_pkg::npic_vec_t vec;
	logic [21:0] exq[$];
	int fails = 0;
	int n_compared = 0;
	int n_svc = 0;
	int npush = 0;
	int i, j;

	always #20 hclk = ~hclk;

	npic_ctrl npic_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext0_pins(ext0_pins),
		.ext1_pins(ext1_pins), .periph_flag(periph_flag), .periph_en(periph_en),
		.periph_clr(periph_clr), .cpu_instr_end(cpu_instr_end), .cpu_trap(cpu_trap),
		.cpu_return_from_isr(cpu_return_from_isr), .cpu_return_from_isr_prio(cpu_return_from_isr_prio), .cpu_wait(cpu_wait),
		.cpu_stop(cpu_stop),
		.save(save), .vec(vec), .cc_prio(cc_prio), .wake_wait(wake_wait),
		.wake_stop(wake_stop), .busy(busy));
	npic_cpu_model npic_cpu_model_i (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.return_from_isr_req(return_from_isr_req), .save(save), .cc_prio(cc_prio), .cpu_instr_end(cpu_instr_end),
		.cpu_return_from_isr(cpu_return_from_isr), .cpu_return_from_isr_prio(cpu_return_from_isr_prio));

	task cmp_reg(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cmp_svc(input logic [21:0] g, input logic [21:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// watch vector loads, count pushes
	always @(posedge hclk) begin
		#1;
		if (save.push === 1'b1)
			npush++;
		if (vec.load === 1'b1) begin
			cmp_svc({npush[3:0], vec.addr, cc_prio}, exq.size() ? exq.pop_front() : 22'h3FFFFF);
			npush = 0;
			n_svc++;
		end
	end
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, a, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		cmp_reg(r, e);
	endtask
	task svc(input logic [15:0] a, input logic [1:0] c);
		int k;
		k = n_svc;
		exq.push_back({4'h4, a, c});
		repeat (300) if (n_svc == k) @(posedge hclk);
	endtask
	task clr(input int k);
		periph_flag[k] <= 1'b0;
		periph_clr[k] <= 1'b1;
		@(posedge hclk);
		periph_clr <= 14'h0;
	endtask
	task ret;
		return_from_isr_req <= 1'b1;
		@(posedge hclk);
		return_from_isr_req <= 1'b0;
		@(posedge hclk);
	endtask
	task idle;
		repeat (20) @(posedge hclk);
		cmp_reg({30'h0, hresp, busy}, 32'h0);
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	task end_of_test;
		if (exq.size() != 0)
			fails++;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h85dc));
		exq.push_back({4'h0, npic_pkg::VEC_RESET, npic_pkg::LVL3_CODE});
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		rdc(npic_pkg::IDX_PRIO3, 32'hFF);
		rdc(8'h10, 32'h0);
		wr(npic_pkg::IDX_PRIO0, 32'hCF);
		wr(npic_pkg::IDX_PRIO0, 32'h64);
		rdc(npic_pkg::IDX_PRIO0, 32'h44);
		wr(npic_pkg::IDX_PRIO0, 32'hDF);
		done("registers");
		periph_flag <= 14'h0014;
		idle();
		wr(npic_pkg::IDX_CC, 32'h20);
		svc(16'hFFF2, 2'h3);
		clr(4);
		ret();
		svc(16'hFFF6, 2'h1);
		clr(2);
		ret();
		done("software priority");
		i = 3 + $urandom % 10;
		j = i + 1 + $urandom % (13 - i);
		slow <= 1'($urandom);
		periph_flag[i] <= 1'b1;
		periph_flag[j] <= 1'b1;
		svc(16'hFFFA - 16'(2 * i), 2'h3);
		clr(i);
		ret();
		svc(16'hFFFA - 16'(2 * j), 2'h3);
		clr(j);
		ret();
		done("hardware order");
		periph_en[5] <= 1'b0;
		periph_flag[5] <= 1'b1;
		idle();
		periph_flag[5] <= 1'b0;
		periph_en[5] <= 1'b1;
		cpu_trap <= 1'b1;
		cpu_wait <= 1'b1;
		cpu_stop <= 1'b1;
		@(posedge hclk);
		cpu_trap <= 1'b0;
		repeat (2) @(posedge hclk);
		cmp_reg({30'h0, wake_stop, wake_wait}, 32'h3);
		cpu_wait <= 1'b0;
		cpu_stop <= 1'b0;
		svc(npic_pkg::VEC_TRAP, 2'h3);
		ret();
		done("trap");
		wr(npic_pkg::IDX_SEL0, 32'h03);
		wr(npic_pkg::IDX_SENSE, 32'h01);
		ext0_pins <= 8'hFE;
		svc(16'hFFFA, 2'h3);
		ext0_pins <= 8'hFC;
		ret();
		idle();
		wr(npic_pkg::IDX_SEL1, 32'h03);
		ext1_pins <= 8'hFD;
		svc(16'hFFF8, 2'h3);
		ext1_pins <= 8'hFF;
		ret();
		done("external edge");
		cpu_stop <= 1'b1;
		periph_flag[4] <= 1'b1;
		periph_flag[5] <= 1'b1;
		repeat (3) @(posedge hclk);
		cmp_reg({30'h0, wake_stop, wake_wait}, 32'h2);
		cpu_stop <= 1'b0;
		rdc(npic_pkg::IDX_PEND_LO, 32'h30);
		svc(16'hFFF0, 2'h3);
		clr(5);
		ret();
		svc(16'hFFF2, 2'h3);
		clr(4);
		ret();
		done("stop exit");
		end_of_test();
	end
endmodule

// ---- src/npic_arbiter.sv ----
// Purpose: picks the maskable vector to serve
// Assumes: lower index means higher hardware priority
// Notes: purely combinational
`timescale 1ns/1ps
module npic_arbiter (
	// requests
	input wire logic [13:0] req,
	input wire logic [27:0] prio,
	// current state
	input wire logic [1:0] cur_rank,
	input wire logic stop_only,
	// result
	output logic hit,
	output logic [3:0] idx
);
	logic [13:0] elig;
	logic [1:0] rank [14];
	logic [1:0] best;

	genvar g;
	generate
		for (g = 0; g < npic_pkg::NVEC; g++) begin : g_vec
			assign rank[g] = npic_pkg::npic_rank(prio[2*g +: 2]);
			assign elig[g] = req[g] & (rank[g] > cur_rank)
				& (~stop_only | npic_pkg::STOP_CAP[g]);
		end
	endgenerate

	// highest rank first, ties to the lowest index
	always_comb begin
		hit = 1'b0;
		idx = 4'h0;
		best = 2'h0;
		for (int i = npic_pkg::NVEC - 1; i >= 0; i--) begin
			if (elig[i] && (!hit || rank[i] >= best)) begin
				hit = 1'b1;
				idx = 4'(i);
				best = rank[i];
			end
		end
	end
endmodule

// ---- src/npic_ctrl.sv ----
// Purpose: nested interrupt controller with AHB-Lite register access
// Assumes: cpu handshake signals synchronous to hclk
// Notes: vectors 0 and 1 are external pin groups, the rest peripherals
//
// Overview of operation
// - on acceptance, after the instruction ends, push PC, X, A, CC in order.
// - entering a maskable routine loads CC level bits from that vector's field.
// - after saving, present the served vector for the program counter load.
// - return from interrupt restores the stacked level bits.
// - level codes 10, 01, 00, 11 mean levels 0 to 3; 3 masks.
// - highest software level among pending requests wins.
// - equal software levels resolve by fixed hardware order.
// - unserved requests stay latched until they win; here level-mode external requests follow the pins and are not latched.
// - hardware order unique per vector, so one winner always.
// - reset and trap ignore level bits; load vector, set level 3.
// - reset and trap wake from deep stop.
// - trap instruction raises a trap through the normal service flow.
// - reset has top hardware priority and starts at level 3.
// - maskable served only when enabled and above current level.
// - edge external requests latch and clear on routine entry.
// - selected pins of one group are NANDed together.
// - peripheral requests only while flag and enable are both set; here the latch holds the request until the clear sequence.
// - peripheral clear sequence discards its pending request latch.
// - any request wakes wait; only stop-capable ones wake deep stop.
// - first service after deep stop is a stop-capable winner.
// - sixteen vectors from FFE0h to FFFFh in hardware order.
// - writing the level 0 code into a priority field is ignored.
// - priority registers hold two bits per vector, reset to all ones.
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module npic_ctrl (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// external pins
	input wire logic [7:0] ext0_pins,
	input wire logic [7:0] ext1_pins,
	// peripheral requests
	input wire logic [13:0] periph_flag,
	input wire logic [13:0] periph_en,
	input wire logic [13:0] periph_clr,
	// cpu handshake
	input wire logic cpu_instr_end,
	input wire logic cpu_trap,
	input wire logic cpu_return_from_isr,
	input wire logic [1:0] cpu_return_from_isr_prio,
	input wire logic cpu_wait,
	input wire logic cpu_stop,
	// cpu control
	output npic_pkg::npic_save_t save,
	output npic_pkg::npic_vec_t vec,
	output logic [1:0] cc_prio,
	output logic wake_wait,
	output logic wake_stop,
	output logic busy
);
	npic_pkg::npic_state_t state;
	logic [7:0] prio_reg [4];
	logic [7:0] pin_sel [2];
	logic [1:0] sense;
	logic [13:0] periph_latch;
	logic [13:0] req;
	logic [1:0] ext_req;
	logic [1:0] ext_clr;
	logic [27:0] prio_flat;
	logic arb_hit;
	logic [3:0] arb_idx;
	logic reset_pend;
	logic trap_pend;
	logic stop_exit;
	logic serve_trap;
	logic serve_reset;
	logic [3:0] serve_idx;
	logic [1:0] item;
	logic accept;
	logic dp_write;
	logic [7:0] dp_idx;
	logic ap_valid;
	logic [7:0] ap_idx;
	logic [31:0] next_rdata;

	// bus address phase
	assign ap_valid = hsel & hready & htrans[1];
	assign ap_idx = haddr[9:2];

	// request sources
	genvar g;
	generate
		for (g = 0; g < npic_pkg::NVEC; g++) begin : g_src
			if (g < npic_pkg::NEXT_GRP) begin : g_ext
				npic_ext_group u_ext (
					.hclk(hclk),
					.hresetn(hresetn),
					.pins(g == 0 ? ext0_pins : ext1_pins),
					.sel(pin_sel[g]),
					.edge_mode(sense[g]),
					.clr(ext_clr[g]),
					.req(ext_req[g])
				);
				assign req[g] = ext_req[g];
				assign ext_clr[g] = (state == npic_pkg::ST_LOAD) & !serve_trap
					& !serve_reset & (serve_idx == 4'(g));
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						periph_latch[g] <= 1'b0;
					end else begin
						periph_latch[g] <= 1'b0;
					end
				end
			end else begin : g_per
				// peripheral latch, clear sequence drops it
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						periph_latch[g] <= 1'b0;
					end else if (periph_clr[g]) begin
						periph_latch[g] <= 1'b0;
					end else if (periph_flag[g] && periph_en[g]) begin
						periph_latch[g] <= 1'b1;
					end
				end
				assign req[g] = periph_latch[g];
			end
			assign prio_flat[2*g +: 2] = prio_reg[g / 4][2*(g % 4) +: 2];
		end
	endgenerate

	npic_arbiter u_arb (
		.req(req),
		.prio(prio_flat),
		.cur_rank(npic_pkg::npic_rank(cc_prio)),
		.stop_only(stop_exit),
		.hit(arb_hit),
		.idx(arb_idx)
	);

	assign accept = cpu_instr_end & (trap_pend | arb_hit);

	// service sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= npic_pkg::ST_IDLE;
			serve_trap <= 1'b0;
			serve_reset <= 1'b0;
			serve_idx <= 4'h0;
			item <= 2'h0;
		end else begin
			unique case (state)
				npic_pkg::ST_IDLE: begin
					item <= 2'h0;
					if (reset_pend) begin
						serve_reset <= 1'b1;
						serve_trap <= 1'b0;
						state <= npic_pkg::ST_LOAD;
					end else if (accept) begin
						serve_reset <= 1'b0;
						serve_trap <= trap_pend;
						serve_idx <= arb_idx;
						state <= npic_pkg::ST_SAVE;
					end
				end
				npic_pkg::ST_SAVE: begin
					item <= item + 2'h1;
					if (item == 2'(npic_pkg::CTX_ITEMS - 1)) begin
						state <= npic_pkg::ST_LOAD;
					end
				end
				npic_pkg::ST_LOAD: begin
					serve_reset <= 1'b0;
					state <= npic_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// context push strobes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			save <= '0;
		end else begin
			save.push <= (state == npic_pkg::ST_SAVE);
			save.item <= item;
		end
	end

	// vector load
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vec <= '0;
		end else begin
			vec.load <= (state == npic_pkg::ST_LOAD);
			if (state == npic_pkg::ST_LOAD) begin
				if (serve_reset) begin
					vec.addr <= npic_pkg::VEC_RESET;
				end else if (serve_trap) begin
					vec.addr <= npic_pkg::VEC_TRAP;
				end else begin
					vec.addr <= npic_pkg::VEC_TOP - {11'h000, serve_idx, 1'b0};
				end
			end
		end
	end

	// current level bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cc_prio <= npic_pkg::LVL3_CODE;
		end else if (state == npic_pkg::ST_LOAD) begin
			if (serve_reset || serve_trap) begin
				cc_prio <= npic_pkg::LVL3_CODE;
			end else begin
				cc_prio <= prio_flat[2*serve_idx +: 2];
			end
		end else if (cpu_return_from_isr) begin
			cc_prio <= cpu_return_from_isr_prio;
		end else if (dp_write && dp_idx == npic_pkg::IDX_CC) begin
			cc_prio <= {hwdata[npic_pkg::CC_BIT_HI], hwdata[npic_pkg::CC_BIT_LO]};
		end
	end

	// reset and trap pending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_pend <= 1'b1;
			trap_pend <= 1'b0;
		end else begin
			if (state == npic_pkg::ST_LOAD && serve_reset) begin
				reset_pend <= 1'b0;
			end
			if (cpu_trap) begin
				trap_pend <= 1'b1;
			end else if (state == npic_pkg::ST_LOAD && serve_trap) begin
				trap_pend <= 1'b0;
			end
		end
	end

	// stop exit restriction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_exit <= 1'b0;
		end else if (cpu_stop) begin
			stop_exit <= 1'b1;
		end else if (state == npic_pkg::ST_LOAD) begin
			stop_exit <= 1'b0;
		end
	end

	// wake-up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_wait <= 1'b0;
			wake_stop <= 1'b0;
			busy <= 1'b0;
		end else begin
			wake_wait <= cpu_wait & ((|req) | trap_pend);
			wake_stop <= cpu_stop & ((|(req & npic_pkg::STOP_CAP))
				| trap_pend | reset_pend);
			busy <= (state != npic_pkg::ST_IDLE) | reset_pend;
		end
	end

	// bus data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_idx <= 8'h00;
		end else begin
			dp_write <= ap_valid & hwrite;
			if (ap_valid) begin
				dp_idx <= ap_idx;
			end
		end
	end

	// priority registers, level 0 code keeps old field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int r = 0; r < npic_pkg::NPRIO_REG; r++) begin
				prio_reg[r] <= npic_pkg::PRIO_RST;
			end
		end else if (dp_write && dp_idx >= npic_pkg::IDX_PRIO0
			&& dp_idx <= npic_pkg::IDX_PRIO3) begin
			for (int f = 0; f < 4; f++) begin
				if (hwdata[2*f +: 2] != npic_pkg::LVL0_CODE) begin
					prio_reg[2'(dp_idx - npic_pkg::IDX_PRIO0)][2*f +: 2] <= hwdata[2*f +: 2];
				end
			end
		end
	end

	// pin selection and sense
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sel[0] <= 8'h00;
			pin_sel[1] <= 8'h00;
			sense <= 2'h0;
		end else if (dp_write) begin
			if (dp_idx == npic_pkg::IDX_SEL0) begin
				pin_sel[0] <= hwdata[7:0];
			end
			if (dp_idx == npic_pkg::IDX_SEL1) begin
				pin_sel[1] <= hwdata[7:0];
			end
			if (dp_idx == npic_pkg::IDX_SENSE) begin
				sense <= hwdata[1:0];
			end
		end
	end

	// read mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (ap_idx >= npic_pkg::IDX_PRIO0 && ap_idx < npic_pkg::IDX_PRIO3) begin
			next_rdata[7:0] = prio_reg[2'(ap_idx - npic_pkg::IDX_PRIO0)];
		end else if (ap_idx == npic_pkg::IDX_PRIO3) begin
			next_rdata[7:0] = prio_reg[3] | npic_pkg::PRIO3_RO;
		end else if (ap_idx == npic_pkg::IDX_SEL0) begin
			next_rdata[7:0] = pin_sel[0];
		end else if (ap_idx == npic_pkg::IDX_SEL1) begin
			next_rdata[7:0] = pin_sel[1];
		end else if (ap_idx == npic_pkg::IDX_SENSE) begin
			next_rdata[1:0] = sense;
		end else if (ap_idx == npic_pkg::IDX_CC) begin
			next_rdata[npic_pkg::CC_BIT_HI] = cc_prio[1];
			next_rdata[npic_pkg::CC_BIT_LO] = cc_prio[0];
		end else if (ap_idx == npic_pkg::IDX_PEND_LO) begin
			next_rdata[7:0] = req[7:0];
		end else if (ap_idx == npic_pkg::IDX_PEND_HI) begin
			next_rdata[5:0] = req[13:8];
		end else if (ap_idx == npic_pkg::IDX_STATE) begin
			next_rdata[6:0] = {stop_exit, trap_pend, reset_pend, 1'b0, state};
		end
	end

	// bus response, zero wait, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (ap_valid && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end
endmodule

// ---- src/npic_ext_group.sv ----
// Purpose: one external pin group feeding one vector
// Assumes: pins are active low and synchronous to hclk
// Notes: edge mode latches until the vector is entered
`timescale 1ns/1ps
module npic_ext_group (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pins and setup
	input wire logic [7:0] pins,
	input wire logic [7:0] sel,
	input wire logic edge_mode,
	// service
	input wire logic clr,
	output logic req
);
	logic active;
	logic prev;
	logic latch;

	// selected pins nanded, unselected count as high
	assign active = (|sel) & ~(&(pins | ~sel));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= 1'b0;
		end else begin
			prev <= active;
		end
	end

	// edge latch, a new edge wins over the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch <= 1'b0;
		end else if (active && !prev) begin
			latch <= 1'b1;
		end else if (clr) begin
			latch <= 1'b0;
		end
	end

	assign req = edge_mode ? latch : active;
endmodule

// ---- src/npic_pkg.sv ----
// Purpose: shared constants, types and helpers of the nested interrupt controller
// Assumes: 14 maskable vectors, two external pin groups of eight pins
// Notes: register indices become byte addresses at four times the index
package npic_pkg;
	localparam int NVEC = 14;
	localparam int NPIN = 8;
	localparam int NPRIO_REG = 4;
	localparam int NEXT_GRP = 2;
	localparam int CTX_ITEMS = 4;

	// register indices, byte address is index * 4
	localparam logic [7:0] IDX_PRIO0 = 8'h1C;
	localparam logic [7:0] IDX_PRIO3 = 8'h1F;
	localparam logic [7:0] IDX_SEL0 = 8'h20;
	localparam logic [7:0] IDX_SEL1 = 8'h21;
	localparam logic [7:0] IDX_SENSE = 8'h22;
	localparam logic [7:0] IDX_CC = 8'h23;
	localparam logic [7:0] IDX_PEND_LO = 8'h24;
	localparam logic [7:0] IDX_PEND_HI = 8'h25;
	localparam logic [7:0] IDX_STATE = 8'h26;

	// priority codes of the two level bits
	localparam logic [1:0] LVL0_CODE = 2'h2;
	localparam logic [1:0] LVL1_CODE = 2'h1;
	localparam logic [1:0] LVL2_CODE = 2'h0;
	localparam logic [1:0] LVL3_CODE = 2'h3;
	localparam logic [7:0] PRIO_RST = 8'hFF;
	localparam logic [7:0] PRIO3_RO = 8'hF0;
	localparam int CC_BIT_HI = 5;
	localparam int CC_BIT_LO = 3;

	// vectors
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_TOP = 16'hFFFA;
	localparam logic [13:0] STOP_CAP = 14'h002B;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAVE = 3'b010,
		ST_LOAD = 3'b100
	} npic_state_t;

	typedef struct packed {
		logic push;
		logic [1:0] item;
	} npic_save_t;

	typedef struct packed {
		logic load;
		logic [15:0] addr;
	} npic_vec_t;

	function automatic logic [1:0] npic_rank(input logic [1:0] code);
		logic [1:0] r;
		r = 2'h0;
		unique case (code)
			LVL0_CODE: r = 2'h0;
			LVL1_CODE: r = 2'h1;
			LVL2_CODE: r = 2'h2;
			LVL3_CODE: r = 2'h3;
		endcase
		return r;
	endfunction
endpackage
